// ===== include/ppl_pkg.sv
// How it works
// - counted levels lock out after five failures
// - all clear removes lock and resets settings
// - no-lock level refuses password entry writes
// - registered password applies level restrictions
// - password entry read never returns password
// - read shows failures counted, else zero, or no-lock value when unregistered
// - blocked access refused with lock indication
// - self-updated parameters always keep updating
// - right password unlocks unless locked out, wrong raises error
// - all clear refused while motor runs
// - all clear codes unlock from any source
// - partial clear unlocks only from option
// - level writable only without registered password
// - panel copy refused while locked
// - jog screen hidden for levels 4,5,104,105
// - contrast setting stays open on panel
// - level picks panel and network permissions
// - zero or no-lock password entry write always accepted silently
package ppl_pkg;
    // value widths
    localparam int unsigned PPL_VW  = 14;
    localparam int unsigned PPL_DW  = 16;
    localparam int unsigned PPL_AW  = 4;

    // register offsets (word index)
    localparam logic [3:0]  PPL_OFS_LEVEL = 4'h0;
    localparam logic [3:0]  PPL_OFS_PW    = 4'h1;
    localparam logic [3:0]  PPL_OFS_STAT  = 4'h2;

    // status field positions
    localparam int unsigned PPL_ST_REG    = 0;
    localparam int unsigned PPL_ST_LOCKO  = 1;
    localparam int unsigned PPL_ST_FAIL   = 2;
    localparam int unsigned PPL_ST_RUN    = 5;

    // setting values
    localparam logic [13:0] PPL_NO_LOCK   = 14'h270f;
    localparam logic [13:0] PPL_PW_MIN    = 14'h03e8;
    localparam logic [13:0] PPL_PW_MAX    = 14'h270e;
    localparam logic [13:0] PPL_LVL_UG    = 14'h0063;
    localparam logic [13:0] PPL_LVL_CBASE = 14'h0064;
    localparam logic [13:0] PPL_LVL_CTOP  = 14'h006a;
    localparam logic [13:0] PPL_LVL_CUG   = 14'h00c7;
    localparam logic [13:0] PPL_LVL_TOP   = 14'h0006;
    localparam logic [2:0]  PPL_FAIL_MAX  = 3'h5;

    // clear command codes
    localparam logic [15:0] PPL_CLR_ALL_A  = 16'h9966;
    localparam logic [15:0] PPL_CLR_ALL_B  = 16'h55aa;
    localparam logic [15:0] PPL_CLR_PART_A = 16'h9696;
    localparam logic [15:0] PPL_CLR_PART_B = 16'h5a5a;

    // access sources
    localparam logic [1:0]  PPL_SRC_PANEL = 2'h0;
    localparam logic [1:0]  PPL_SRC_RS485 = 2'h1;
    localparam logic [1:0]  PPL_SRC_OPT   = 2'h2;
    localparam logic [1:0]  PPL_SRC_SELF  = 2'h3;

    // access kinds
    localparam logic [1:0]  PPL_KIND_PARAM    = 2'h0;
    localparam logic [1:0]  PPL_KIND_CONTRAST = 2'h1;
    localparam logic [1:0]  PPL_KIND_COPY     = 2'h2;

    // permission masks {pan r,pan w,rs r,rs w,opt r,opt w}
    localparam logic [5:0]  PPL_PERM_ALL = 6'h3f;
    localparam logic [5:0]  PPL_PERM_L0  = 6'h00;
    localparam logic [5:0]  PPL_PERM_L1  = 6'h2a;
    localparam logic [5:0]  PPL_PERM_L2  = 6'h2f;
    localparam logic [5:0]  PPL_PERM_L3  = 6'h3a;
    localparam logic [5:0]  PPL_PERM_L4  = 6'h02;
    localparam logic [5:0]  PPL_PERM_L5  = 6'h0f;
    localparam logic [5:0]  PPL_PERM_L6  = 6'h32;

    // whole block state
    typedef struct packed {
        logic [13:0] level;
        logic [13:0] pw;
        logic        registered;
        logic [2:0]  fails;
        logic [15:0] rdata;
        logic        grant;
        logic        lock_ind;
        logic        clr_all;
        logic        clr_part;
        logic        clr_ref;
        logic        unlock_err;
        logic        wr_ref;
        logic        jog_hide;
        logic        run_m;
        logic        run_s;
    } ppl_state_t;
endpackage

// ===== verilog/ppl_lock.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module ppl_lock import ppl_pkg::*; (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        acc_valid,
    input  wire logic [1:0]  acc_src,
    input  wire logic        acc_write,
    input  wire logic [1:0]  acc_kind,
    output logic             acc_grant,
    output logic             acc_lock_ind,
    input  wire logic        clr_valid,
    input  wire logic [1:0]  clr_src,
    input  wire logic [15:0] clr_code,
    input  wire logic        motor_running,
    output logic             clr_all_done,
    output logic             clr_part_done,
    output logic             clr_refused,
    output logic             unlock_err,
    output logic             wr_refused,
    output logic             jog_screen_hide,
    input  wire logic        nv_load,
    input  wire logic [13:0] nv_level,
    input  wire logic [13:0] nv_pw,
    input  wire logic        nv_registered,
    input  wire logic [2:0]  nv_fails,
    output logic      [13:0] lock_level_q,
    output logic      [13:0] password_q,
    output logic             registered_q,
    output logic      [2:0]  fails_q
);
    ppl_state_t s_ff;
    ppl_state_t nxt_s;

    logic        counted;
    logic        lockout;
    logic [5:0]  perm;
    logic [13:0] wval;
    logic        w_in_rng;
    logic        w_silent;
    logic        lvl_ok;
    logic        clr_is_all;
    logic        clr_is_part;

    // level class and lockout state
    assign counted = ((s_ff.level >= PPL_LVL_CBASE)
                      && (s_ff.level <= PPL_LVL_CTOP))
                     || (s_ff.level == PPL_LVL_CUG);
    assign lockout = counted && (s_ff.fails == PPL_FAIL_MAX);

    // written value checks
    assign wval     = reg_wdata[13:0];
    assign w_in_rng = (reg_wdata[15:14] == 2'h0) && (wval >= PPL_PW_MIN)
                      && (wval <= PPL_PW_MAX);
    assign w_silent = (reg_wdata == 16'h0000)
                      || (reg_wdata == {2'h0, PPL_NO_LOCK});
    assign lvl_ok   = (reg_wdata[15:14] == 2'h0)
                      && ((wval <= PPL_LVL_TOP) || (wval == PPL_LVL_UG)
                          || ((wval >= PPL_LVL_CBASE)
                              && (wval <= PPL_LVL_CTOP))
                          || (wval == PPL_LVL_CUG)
                          || (wval == PPL_NO_LOCK));

    assign clr_is_all  = (clr_code == PPL_CLR_ALL_A)
                         || (clr_code == PPL_CLR_ALL_B);
    assign clr_is_part = (clr_code == PPL_CLR_PART_A)
                         || (clr_code == PPL_CLR_PART_B);

    // permission mask for the current level
    always_comb begin
        perm = PPL_PERM_ALL;
        if (s_ff.registered) begin
            if (s_ff.level == PPL_LVL_UG || s_ff.level == PPL_LVL_CUG) begin
                perm = PPL_PERM_L4;
            end else begin
                case (s_ff.level >= PPL_LVL_CBASE ?
                      14'(s_ff.level - PPL_LVL_CBASE) : s_ff.level)
                    14'h0000: perm = PPL_PERM_L0;
                    14'h0001: perm = PPL_PERM_L1;
                    14'h0002: perm = PPL_PERM_L2;
                    14'h0003: perm = PPL_PERM_L3;
                    14'h0004: perm = PPL_PERM_L4;
                    14'h0005: perm = PPL_PERM_L5;
                    14'h0006: perm = PPL_PERM_L6;
                    default:  perm = PPL_PERM_ALL;
                endcase
            end
        end
    end

    // next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdata      = 16'h0000;
        nxt_s.grant      = 1'b0;
        nxt_s.lock_ind   = 1'b0;
        nxt_s.clr_all    = 1'b0;
        nxt_s.clr_part   = 1'b0;
        nxt_s.clr_ref    = 1'b0;
        nxt_s.unlock_err = 1'b0;
        nxt_s.wr_ref     = 1'b0;
        // motor running pin synchroniser
        nxt_s.run_m = motor_running;
        nxt_s.run_s = s_ff.run_m;
        // jog screen suppression
        nxt_s.jog_hide = s_ff.registered
                         && (s_ff.level == 14'h0004
                             || s_ff.level == 14'h0005
                             || s_ff.level == 14'h0068
                             || s_ff.level == 14'h0069);

        // restore saved settings
        if (nv_load) begin
            nxt_s.level      = nv_level;
            nxt_s.pw         = nv_pw;
            nxt_s.registered = nv_registered;
            nxt_s.fails      = (nv_fails > PPL_FAIL_MAX) ?
                               PPL_FAIL_MAX : nv_fails;
        end

        // lock level writes
        if (reg_wr && reg_addr == PPL_OFS_LEVEL) begin
            if (!s_ff.registered && lvl_ok) begin
                nxt_s.level = wval;
            end else begin
                nxt_s.wr_ref = 1'b1;
            end
        end

        // password entry writes
        if (reg_wr && reg_addr == PPL_OFS_PW) begin
            if (w_silent) begin
                nxt_s.wr_ref = 1'b0;
            end else if (s_ff.level == PPL_NO_LOCK || !w_in_rng) begin
                nxt_s.wr_ref = 1'b1;
            end else if (!s_ff.registered) begin
                nxt_s.pw         = wval;
                nxt_s.registered = 1'b1;
                nxt_s.fails      = 3'h0;
            end else if (!lockout && wval == s_ff.pw) begin
                nxt_s.registered = 1'b0;
                nxt_s.fails      = 3'h0;
            end else begin
                nxt_s.unlock_err = 1'b1;
                if (counted && s_ff.fails < PPL_FAIL_MAX) begin
                    nxt_s.fails = 3'(s_ff.fails + 3'h1);
                end
            end
        end

        // register reads, data stands next cycle only
        if (reg_rd) begin
            case (reg_addr)
                PPL_OFS_LEVEL: nxt_s.rdata = {2'h0, s_ff.level};
                PPL_OFS_PW: begin
                    if (!s_ff.registered) begin
                        nxt_s.rdata = {2'h0, PPL_NO_LOCK};
                    end else if (counted) begin
                        nxt_s.rdata = {13'h0000, s_ff.fails};
                    end else begin
                        nxt_s.rdata = 16'h0000;
                    end
                end
                PPL_OFS_STAT: begin
                    nxt_s.rdata[PPL_ST_REG]   = s_ff.registered;
                    nxt_s.rdata[PPL_ST_LOCKO] = lockout;
                    nxt_s.rdata[PPL_ST_FAIL +: 3] = s_ff.fails;
                    nxt_s.rdata[PPL_ST_RUN]   = s_ff.run_s;
                end
                default: nxt_s.rdata = 16'h0000;
            endcase
        end

        // parameter access gating
        if (acc_valid) begin
            if (acc_src == PPL_SRC_SELF) begin
                nxt_s.grant = 1'b1;
            end else if (acc_kind == PPL_KIND_CONTRAST
                         && acc_src == PPL_SRC_PANEL) begin
                nxt_s.grant = 1'b1;
            end else if (acc_kind == PPL_KIND_COPY) begin
                nxt_s.grant    = !s_ff.registered;
                nxt_s.lock_ind = s_ff.registered;
            end else begin
                case (acc_src)
                    PPL_SRC_PANEL: nxt_s.grant = acc_write ? perm[4]
                                                           : perm[5];
                    PPL_SRC_RS485: nxt_s.grant = acc_write ? perm[2]
                                                           : perm[3];
                    default:       nxt_s.grant = acc_write ? perm[0]
                                                           : perm[1];
                endcase
                nxt_s.lock_ind = !nxt_s.grant;
            end
        end

        // clear commands win over everything else
        if (clr_valid) begin
            if (s_ff.run_s && clr_is_all) begin
                nxt_s.clr_ref = 1'b1;
            end else if (clr_is_all) begin
                nxt_s.level      = PPL_NO_LOCK;
                nxt_s.pw         = PPL_NO_LOCK;
                nxt_s.registered = 1'b0;
                nxt_s.fails      = 3'h0;
                nxt_s.clr_all    = 1'b1;
            end else if (clr_is_part && s_ff.registered
                         && clr_src != PPL_SRC_OPT) begin
                nxt_s.clr_ref = 1'b1;
            end else if (clr_is_part) begin
                nxt_s.registered = 1'b0;
                nxt_s.fails      = 3'h0;
                nxt_s.clr_part   = 1'b1;
            end else begin
                nxt_s.clr_ref = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff       <= '0;
            s_ff.level <= PPL_NO_LOCK;
            s_ff.pw    <= PPL_NO_LOCK;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata       = s_ff.rdata;
    assign acc_grant       = s_ff.grant;
    assign acc_lock_ind    = s_ff.lock_ind;
    assign clr_all_done    = s_ff.clr_all;
    assign clr_part_done   = s_ff.clr_part;
    assign clr_refused     = s_ff.clr_ref;
    assign unlock_err      = s_ff.unlock_err;
    assign wr_refused      = s_ff.wr_ref;
    assign jog_screen_hide = s_ff.jog_hide;
    assign lock_level_q    = s_ff.level;
    assign password_q      = s_ff.pw;
    assign registered_q    = s_ff.registered;
    assign fails_q         = s_ff.fails;

    // checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_pw_write;
        reg_wr && reg_addr == PPL_OFS_PW && !clr_valid && !nv_load;
    endsequence

    sequence s_bad_try;
        s_pw_write ##0 (s_ff.registered && !lockout && w_in_rng
                        && wval != s_ff.pw && s_ff.level != PPL_NO_LOCK);
    endsequence

    sequence s_all_clear;
        clr_valid && clr_is_all && !s_ff.run_s;
    endsequence

    a_lockout_holds: assert property (
        (s_pw_write ##0 (s_ff.registered && lockout)) |=> s_ff.registered
            && s_ff.fails == PPL_FAIL_MAX)
        else $error("lockout was lifted by a password");
    a_all_clear_unlocks: assert property (
        s_all_clear |=> !s_ff.registered && s_ff.fails == 3'h0
            && s_ff.level == PPL_NO_LOCK && clr_all_done)
        else $error("all clear left the lock in place");
    a_nolock_refuse: assert property (
        (s_pw_write ##0 (s_ff.level == PPL_NO_LOCK && w_in_rng
                         && !s_ff.registered && !nv_load))
            |=> wr_refused && !s_ff.registered)
        else $error("password taken with no-lock level");
    a_pw_read_hidden: assert property (
        (reg_rd && reg_addr == PPL_OFS_PW && s_ff.registered)
            |=> reg_rdata <= 16'h0005)
        else $error("password entry read out of range");
    a_uncounted_zero: assert property (
        (reg_rd && reg_addr == PPL_OFS_PW && s_ff.registered && !counted)
            |=> reg_rdata == 16'h0000)
        else $error("uncounted level read nonzero");
    a_locked_denied: assert property (
        (acc_valid && acc_kind == PPL_KIND_PARAM && acc_src != PPL_SRC_SELF
         && s_ff.registered && s_ff.level == 14'h0000)
            |=> acc_lock_ind && !acc_grant)
        else $error("blocked access was granted");
    a_self_granted: assert property (
        (acc_valid && acc_src == PPL_SRC_SELF) |=> acc_grant)
        else $error("self update was refused");
    a_bad_pw_error: assert property (
        s_bad_try |=> (unlock_err && s_ff.registered)
            ##1 (!unlock_err || $past(reg_wr)))
        else $error("wrong password gave no single error pulse");
    a_run_refuses: assert property (
        (clr_valid && clr_is_all && s_ff.run_s) |=> clr_refused
            && !clr_all_done)
        else $error("all clear done while running");
    a_part_refused: assert property (
        (clr_valid && clr_is_part && s_ff.registered && !reg_wr && !nv_load
         && clr_src != PPL_SRC_OPT) |=> clr_refused && s_ff.registered)
        else $error("partial clear unlocked from panel or link");
    a_level_frozen: assert property (
        (reg_wr && reg_addr == PPL_OFS_LEVEL && s_ff.registered
         && !clr_valid && !nv_load) |=> $stable(s_ff.level) && wr_refused)
        else $error("level changed while registered");
    a_copy_denied: assert property (
        (acc_valid && acc_kind == PPL_KIND_COPY && acc_src != PPL_SRC_SELF
         && s_ff.registered) |=> !acc_grant)
        else $error("copy allowed while locked");
    a_jog_hidden: assert property (
        (s_ff.registered && s_ff.level == 14'h0068) |=> jog_screen_hide)
        else $error("jog screen shown at read-blocking level");
    a_contrast_open: assert property (
        (acc_valid && acc_kind == PPL_KIND_CONTRAST
         && acc_src == PPL_SRC_PANEL) |=> acc_grant)
        else $error("contrast access refused");
    a_fail_saturate: assert property (
        s_ff.fails <= PPL_FAIL_MAX)
        else $error("failure count above five");
endmodule

// ===== sim/ppl_host_model.sv
`timescale 1ns/1ps
// far-side requester: panel, serial link, option or self update
module ppl_host_model (
    input  wire logic        sys_clk,
    output logic             acc_valid,
    output logic      [1:0]  acc_src,
    output logic             acc_write,
    output logic      [1:0]  acc_kind,
    output logic             clr_valid,
    output logic      [1:0]  clr_src,
    output logic      [15:0] clr_code
);
    // idle at time zero
    initial begin
        acc_valid = 1'b0;
        acc_src   = 2'h0;
        acc_write = 1'b0;
        acc_kind  = 2'h0;
        clr_valid = 1'b0;
        clr_src   = 2'h0;
        clr_code  = 16'h0000;
    end

    // one-cycle access; qualifiers scrambled once the pulse drops
    task automatic access(input logic [1:0] s, input logic w,
                          input logic [1:0] k);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_src   <= s;
        acc_write <= w;
        acc_kind  <= k;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        acc_src   <= ~s;
        acc_write <= ~w;
        acc_kind  <= ~k;
    endtask

    // one-cycle clear command, code scrambled afterwards
    task automatic clear(input logic [1:0] s, input logic [15:0] c);
        @(posedge sys_clk);
        clr_valid <= 1'b1;
        clr_src   <= s;
        clr_code  <= c;
        @(posedge sys_clk);
        clr_valid <= 1'b0;
        clr_src   <= ~s;
        clr_code  <= ~c;
    endtask
endmodule

// ===== sim/parameter_password_lock_tb.sv
`timescale 1ns/1ps
module parameter_password_lock_tb import ppl_pkg::*;;
    logic        sys_clk       = 1'b0;
    logic        rst           = 1'b1;
    logic [3:0]  reg_addr      = 4'h0;
    logic [15:0] reg_wdata     = 16'h0000;
    logic        reg_wr        = 1'b0;
    logic        reg_rd        = 1'b0;
    logic        motor_running = 1'b0;
    logic        nv_load       = 1'b0;
    logic [13:0] nv_level      = 14'h0000;
    logic [13:0] nv_pw         = 14'h0000;
    logic        nv_registered = 1'b0;
    logic [2:0]  nv_fails      = 3'h0;
    logic [15:0] reg_rdata;
    logic        acc_valid, acc_write, clr_valid;
    logic [1:0]  acc_src, acc_kind, clr_src;
    logic [15:0] clr_code;
    logic        acc_grant, acc_lock_ind, clr_all_done, clr_part_done;
    logic        clr_refused, unlock_err, wr_refused, jog_screen_hide;
    logic [13:0] lock_level_q, password_q;
    logic        registered_q;
    logic [2:0]  fails_q;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          lvls [16] = '{0, 1, 2, 3, 4, 5, 6, 99,
                               100, 101, 102, 103, 104, 105, 106, 199};

    ppl_lock dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_src(acc_src),
        .acc_write(acc_write), .acc_kind(acc_kind), .acc_grant(acc_grant),
        .acc_lock_ind(acc_lock_ind), .clr_valid(clr_valid),
        .clr_src(clr_src), .clr_code(clr_code),
        .motor_running(motor_running), .clr_all_done(clr_all_done),
        .clr_part_done(clr_part_done), .clr_refused(clr_refused),
        .unlock_err(unlock_err), .wr_refused(wr_refused),
        .jog_screen_hide(jog_screen_hide), .nv_load(nv_load),
        .nv_level(nv_level), .nv_pw(nv_pw), .nv_registered(nv_registered),
        .nv_fails(nv_fails), .lock_level_q(lock_level_q),
        .password_q(password_q), .registered_q(registered_q),
        .fails_q(fails_q));

    ppl_host_model host (.sys_clk(sys_clk), .acc_valid(acc_valid),
        .acc_src(acc_src), .acc_write(acc_write), .acc_kind(acc_kind),
        .clr_valid(clr_valid), .clr_src(clr_src), .clr_code(clr_code));

    // 20 MHz clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // register bus: one-cycle strobes, answer one cycle later
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // access with expected grant or lock indication
    task automatic acc(input logic [1:0] s, input logic w,
                       input logic [1:0] k, input logic ok);
        host.access(s, w, k);
        #1;
        chk({acc_grant, acc_lock_ind}, ok ? 16'h2 : 16'h1);
    endtask

    // clear with expected {all, partial, refused}
    task automatic clr(input logic [1:0] s, input logic [15:0] c,
                       input logic [15:0] exp);
        host.clear(s, c);
        #1;
        chk({clr_all_done, clr_part_done, clr_refused}, exp);
    endtask

    // permission bits {pan r, pan w, rs r, rs w, opt r, opt w} per level
    function automatic logic [5:0] perm(input int lv);
        case (lv % 100)
            0: perm = 6'h00;
            1: perm = 6'h2a;
            2: perm = 6'h2f;
            3: perm = 6'h3a;
            5: perm = 6'h0f;
            6: perm = 6'h32;
            default: perm = 6'h02;
        endcase
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        int          lv;
        logic [15:0] pw;
        logic [5:0]  pm;
        void'($urandom(36176));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(PPL_OFS_PW, 16'h270f);
        rd(4'hf, 16'h0000);
        wr(4'hf, 16'h0064);
        rd(PPL_OFS_LEVEL, 16'h270f);
        wr(PPL_OFS_PW, 16'h04d2);
        chk(wr_refused, 1'b1);
        chk(registered_q, 1'b0);
        // every lockable level (all but no-lock): restrictions, failure count, unlock
        foreach (lvls[i]) begin
            lv = lvls[i];
            pw = 16'(1000 + $urandom % 8999);
            wr(PPL_OFS_LEVEL, 16'(lv));
            chk(wr_refused, 1'b0);
            wr(PPL_OFS_PW, pw);
            chk(registered_q, 1'b1);
            chk(password_q, pw);
            wr(PPL_OFS_LEVEL, 16'h0003);
            chk(wr_refused, 1'b1);
            // hide flag follows the registered state one cycle later
            chk(jog_screen_hide,
                lv == 4 || lv == 5 || lv == 104 || lv == 105);
            pm = perm(lv);
            for (int s = 0; s < 3; s++)
                for (int w = 0; w < 2; w++)
                    acc(2'(s), 1'(w), PPL_KIND_PARAM,
                        pm[5 - 2 * s - w]);
            acc(2'($urandom % 2), 1'b0, PPL_KIND_COPY, 1'b0);
            acc(PPL_SRC_PANEL, 1'($urandom), PPL_KIND_CONTRAST, 1'b1);
            acc(PPL_SRC_SELF, 1'b1, PPL_KIND_PARAM, 1'b1);
            wr(PPL_OFS_PW, pw == 16'd9998 ? 16'd1000 : pw + 16'd1);
            chk(unlock_err, 1'b1);
            rd(PPL_OFS_PW, lv >= 100 ? 16'h1 : 16'h0);
            wr(PPL_OFS_PW, pw);
            chk(registered_q, 1'b0);
            chk(fails_q, 3'h0);
        end
        // lockout after five failures on a counted level
        wr(PPL_OFS_LEVEL, 16'd101);
        wr(PPL_OFS_PW, 16'd999);
        chk(wr_refused, 1'b1);
        wr(PPL_OFS_PW, 16'd4321);
        repeat (6) begin
            wr(PPL_OFS_PW, 16'd5555);
            chk(unlock_err, 1'b1);
        end
        rd(PPL_OFS_PW, 16'h5);
        wr(PPL_OFS_PW, 16'd4321);
        chk({unlock_err, registered_q}, 16'h3);
        rd(PPL_OFS_STAT, 16'h0017);
        wr(PPL_OFS_PW, 16'h0000);
        chk(wr_refused, 1'b0);
        wr(PPL_OFS_PW, 16'h270f);
        chk(wr_refused, 1'b0);
        rd(PPL_OFS_PW, 16'h5);
        clr(PPL_SRC_PANEL, PPL_CLR_PART_A, 16'h1);
        @(posedge sys_clk);
        motor_running <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(PPL_OFS_STAT, 16'h0037);
        clr(PPL_SRC_RS485, PPL_CLR_ALL_B, 16'h1);
        @(posedge sys_clk);
        motor_running <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clr(2'($urandom % 3), PPL_CLR_ALL_A, 16'h4);
        chk({registered_q, fails_q}, 16'h0);
        chk(lock_level_q, 14'h270f);
        chk(password_q, 14'h270f);
        // all clear from panel, serial link and option sources
        for (int s = 0; s < 3; s++) begin
            wr(PPL_OFS_LEVEL, 16'h0002);
            wr(PPL_OFS_PW, 16'(1500 + s));
            clr(2'(s), s[0] ? PPL_CLR_ALL_B : PPL_CLR_ALL_A, 16'h4);
            chk(registered_q, 1'b0);
        end
        // partial clear: option only
        wr(PPL_OFS_LEVEL, 16'd105);
        wr(PPL_OFS_PW, 16'd2000);
        clr(PPL_SRC_RS485, PPL_CLR_PART_B, 16'h1);
        clr(PPL_SRC_OPT, PPL_CLR_PART_A, 16'h2);
        chk(registered_q, 1'b0);
        clr(PPL_SRC_OPT, 16'h1234, 16'h1);
        // restore saved lock state
        @(posedge sys_clk);
        nv_load       <= 1'b1;
        nv_level      <= 14'd100;
        nv_pw         <= 14'd7777;
        nv_registered <= 1'b1;
        nv_fails      <= 3'h2;
        @(posedge sys_clk);
        nv_load <= 1'b0;
        rd(PPL_OFS_PW, 16'h2);
        wr(PPL_OFS_PW, 16'd7777);
        chk(registered_q, 1'b0);
        wrap_up();
    end
endmodule
